// ==== logic/bscc_pkg.sv ====
// Functional notes
// - Clock mode strap low selects 100 MHz reference, high selects 125 MHz.
// - PLLs make 2.5 GHz lane clock and 250 MHz core clock; only the reference rate is reported.
// - All boot straps latch when the external fundamental reset negates.
// - Strap pins are ignored outside a fundamental reset sequence.
// - Straps from the most recent cold reset readable in switch status.
// - Downstream common-clock strap seeds every downstream slot clock bit.
// - Upstream common-clock strap seeds upstream slot clock bit, writable.
// - Slow strap selects 100 KHz master SMBus, else 400 kHz; fixed.
// - Reset-halt strap holds device in reset until halt bit cleared.
// - Halt bit in switch control overrides strap; external agent clears it.
// - Mode 0 normal, 1 EEPROM init, 2 low latency, 3 both.
// - Low-latency modes cut 8 ns; use with common clock or payload below 2KB.
// - Aux power strap 0 disables aux logic and clears sticky bits.
// - During reset, EEPROM or SMBus may override the four overridable straps.
// - EEPROM initialisation may write any bit of any visible register; here status and clocks ignore writes.
// - Reset without external reset reuses the previously latched straps.
// - Asserted reset-halt strap sets the halt indication in switch status.
package bscc_pkg;
   localparam logic [7:0] ADDR_STATUS   = 8'h00;
   localparam logic [7:0] ADDR_CONTROL  = 8'h04;
   localparam logic [7:0] ADDR_LINK_US  = 8'h08;
   localparam logic [7:0] ADDR_LINK_DS  = 8'h0c;
   localparam logic [7:0] ADDR_CLOCKS   = 8'h10;
   // Status fields
   localparam int ST_REFCLK  = 0;
   localparam int ST_UPSTREAM_COMMON_CLOCK_STRAP  = 1;
   localparam int ST_DOWNSTREAM_COMMON_CLOCK_STRAP  = 2;
   localparam int ST_SMBSLOW = 3;
   localparam int ST_HALT    = 4;
   localparam int ST_MODE    = 5;   // Three bits
   localparam int ST_APWRN   = 8;
   localparam int ST_LOWLAT  = 9;
   localparam int ST_EEINIT  = 10;
   localparam int ST_BADMODE = 11;
   localparam int ST_RUN     = 12;
   // Control fields
   localparam int CT_HALT    = 0;
   localparam int CT_FRST    = 1;
   localparam int CT_APWRN   = 2;
   localparam int CT_STICKY  = 3;
   // Rates in kHz
   localparam logic [31:0] REF_100_KHZ  = 32'd100000;
   localparam logic [31:0] REF_125_KHZ  = 32'd125000;
   localparam logic [31:0] SERDES_KHZ   = 32'd2500000;
   localparam logic [31:0] CORE_KHZ     = 32'd250000;
   localparam logic [15:0] SMB_SLOW_KHZ = 16'd100;
   localparam logic [15:0] SMB_FAST_KHZ = 16'd400;
   localparam logic [7:0]  LOWLAT_NS    = 8'd8;
   localparam logic [2:0]  MODE_MAX     = 3'h3;
   localparam logic [31:0] STICKY_RST   = 32'h0000_0000;
endpackage : bscc_pkg

// ==== logic/bscc_strap_latch.sv ====
`timescale 1ns/1ps
`default_nettype none
// Strap capture register: loads only on the negation edge of the reset pin
module bscc_strap_latch #(
   parameter int W = 9
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   // Capture
   input  wire logic         capture,
   input  wire logic [W-1:0] straps,
   output var  logic [W-1:0] held
);
   logic [W-1:0] held_d;

   // Hold between captures; pin changes elsewhere do nothing
   always_comb begin
      held_d = capture ? straps : held;
   end

   // Register only
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         held <= '0;
      end else begin
         held <= held_d;
      end
   end
endmodule : bscc_strap_latch
`default_nettype wire

// ==== logic/bscc_top.sv ====
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module bscc_top #(
   parameter int NDS = 4
) (
   // Clock and reset
   input  wire logic            core_clk,
   input  wire logic            rst_n,
   // Strap pins and fundamental reset pin
   input  wire logic            fundamental_reset_in_n,
   input  wire logic            ref_clock_freq_select,
   input  wire logic            upstream_common_clock_strap,
   input  wire logic            downstream_common_clock_strap,
   input  wire logic            master_smbus_slow_strap,
   input  wire logic            reset_halt_strap,
   input  wire logic [2:0]      switch_mode_strap,
   input  wire logic            aux_power_disable_n,
   // APB slave
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [31:0]     pwdata,
   output logic [31:0]          prdata,
   output logic                 pready,
   output logic                 pslverr,
   // Configuration outputs
   output logic                 ref_is_125m,
   output logic [15:0]          smbus_khz,
   output logic                 eeprom_init_en,
   output logic                 low_latency_en,
   output logic                 aux_power_en,
   output logic                 sticky_clear,
   output logic                 us_slot_clock,
   output logic [NDS-1:0]       ds_slot_clock,
   output logic                 switch_halted,
   output logic                 switch_run
);
   localparam int SW = 9;

   // Reset pin edge tracking
   logic          pin_q, pin_d;
   logic          in_frst_q, in_frst_d;    // Inside a fundamental reset sequence
   logic          cold_seen_q, cold_seen_d;
   logic          capture, seq_end;
   logic [SW-1:0] strap_vec, held;

   assign strap_vec = {aux_power_disable_n, switch_mode_strap, reset_halt_strap,
                       master_smbus_slow_strap, downstream_common_clock_strap,
                       upstream_common_clock_strap, ref_clock_freq_select};
   // Only a genuine pin negation samples; soft reset keeps old values
   assign capture = fundamental_reset_in_n & ~pin_q;

   bscc_strap_latch #(.W(SW)) u_latch (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .capture  (capture),
      .straps   (strap_vec),
      .held     (held)
   );

   // Decoded strap fields
   logic       s_ref, s_us, s_ds, s_slow, s_halt, s_apwrn;
   logic [2:0] s_mode;
   assign {s_apwrn, s_mode, s_halt, s_slow, s_ds, s_us, s_ref} = held;

   // Sequence bookkeeping
   logic frst_req;
   always_comb begin
      pin_d       = fundamental_reset_in_n;
      in_frst_d   = in_frst_q;
      cold_seen_d = cold_seen_q | capture;
      if (!fundamental_reset_in_n || frst_req) begin
         in_frst_d = 1'b1;
      end else if (seq_end) begin
         in_frst_d = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         // Idle level of the pin, so leaving rst_n is never taken as a negation
         pin_q       <= 1'b1;
         in_frst_q   <= 1'b1;
         cold_seen_q <= 1'b0;
      end else begin
         pin_q       <= pin_d;
         in_frst_q   <= in_frst_d;
         cold_seen_q <= cold_seen_d;
      end
   end

   // Reset sequence states
   typedef enum logic [3:0] {
      BSCC_WAIT = 4'b0001,
      BSCC_LOAD = 4'b0010,
      BSCC_HALT = 4'b0100,
      BSCC_RUN  = 4'b1000
   } bscc_state_e;
   bscc_state_e st_q, st_d;

   // Software-visible state
   logic           halt_q, halt_d;
   logic           apwrn_q, apwrn_d;
   logic           us_q, us_d;
   logic [NDS-1:0] ds_q, ds_d;
   logic [31:0]    sticky_q, sticky_d;
   logic           load_pend_q, load_pend_d;

   // APB decode, zero wait state
   logic wr, rd_ok;
   assign wr    = psel & penable & pwrite;
   assign rd_ok = (paddr == bscc_pkg::ADDR_STATUS) || (paddr == bscc_pkg::ADDR_CONTROL) ||
                  (paddr == bscc_pkg::ADDR_LINK_US) || (paddr == bscc_pkg::ADDR_LINK_DS) ||
                  (paddr == bscc_pkg::ADDR_CLOCKS);
   assign frst_req = wr && paddr == bscc_pkg::ADDR_CONTROL && pwdata[bscc_pkg::CT_FRST];

   // Sequencer: wait for pin release, seed overridables, optional halt
   always_comb begin
      st_d        = st_q;
      halt_d      = halt_q;
      apwrn_d     = apwrn_q;
      us_d        = us_q;
      ds_d        = ds_q;
      sticky_d    = sticky_q;
      load_pend_d = load_pend_q | capture | frst_req;
      seq_end     = 1'b0;
      unique case (st_q)
         BSCC_WAIT: begin
            if (fundamental_reset_in_n && !capture && load_pend_q) begin
               st_d = BSCC_LOAD;
            end
         end
         BSCC_LOAD: begin
            load_pend_d = 1'b0;
            halt_d  = s_halt;
            apwrn_d = s_apwrn;
            us_d    = s_us;
            ds_d    = {NDS{s_ds}};
            if (!s_apwrn) begin
               sticky_d = bscc_pkg::STICKY_RST;
            end
            st_d = s_halt ? BSCC_HALT : BSCC_RUN;
         end
         BSCC_HALT: begin
            if (!halt_q) begin
               st_d    = BSCC_RUN;
               seq_end = 1'b1;
            end
         end
         BSCC_RUN: begin
            seq_end = 1'b1;
         end
      endcase
      if (!fundamental_reset_in_n || frst_req) begin
         st_d = BSCC_WAIT;
      end
      // Register writes; overridable straps writable, others fixed
      if (wr && st_q != BSCC_LOAD) begin
         unique case (paddr)
            bscc_pkg::ADDR_CONTROL: begin
               halt_d   = pwdata[bscc_pkg::CT_HALT];
               apwrn_d  = pwdata[bscc_pkg::CT_APWRN];
               sticky_d = {31'h0000_0000, pwdata[bscc_pkg::CT_STICKY]} | sticky_q;
            end
            bscc_pkg::ADDR_LINK_US: us_d = pwdata[0];
            bscc_pkg::ADDR_LINK_DS: ds_d = pwdata[NDS-1:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_q        <= BSCC_WAIT;
         halt_q      <= 1'b0;
         apwrn_q     <= 1'b1;
         us_q        <= 1'b0;
         ds_q        <= '0;
         sticky_q    <= bscc_pkg::STICKY_RST;
         load_pend_q <= 1'b0;
      end else begin
         st_q        <= st_d;
         halt_q      <= halt_d;
         apwrn_q     <= apwrn_d;
         us_q        <= us_d;
         ds_q        <= ds_d;
         sticky_q    <= sticky_d;
         load_pend_q <= load_pend_d;
      end
   end

   // Read mux
   logic [31:0] status_w, rd_d;
   logic        low_lat, ee_init, bad_mode;
   assign ee_init  = s_mode[0] & (s_mode <= bscc_pkg::MODE_MAX);
   assign low_lat  = s_mode[1] & (s_mode <= bscc_pkg::MODE_MAX);
   assign bad_mode = s_mode > bscc_pkg::MODE_MAX;
   always_comb begin
      status_w = 32'h0000_0000;
      status_w[bscc_pkg::ST_REFCLK]  = s_ref;
      status_w[bscc_pkg::ST_UPSTREAM_COMMON_CLOCK_STRAP]  = s_us;
      status_w[bscc_pkg::ST_DOWNSTREAM_COMMON_CLOCK_STRAP]  = s_ds;
      status_w[bscc_pkg::ST_SMBSLOW] = s_slow;
      status_w[bscc_pkg::ST_HALT]    = s_halt;
      status_w[bscc_pkg::ST_MODE+:3] = s_mode;
      status_w[bscc_pkg::ST_APWRN]   = s_apwrn;
      status_w[bscc_pkg::ST_LOWLAT]  = low_lat;
      status_w[bscc_pkg::ST_EEINIT]  = ee_init;
      status_w[bscc_pkg::ST_BADMODE] = bad_mode;
      status_w[bscc_pkg::ST_RUN]     = (st_q == BSCC_RUN) & cold_seen_q;
      rd_d = 32'h0000_0000;
      unique case (paddr)
         bscc_pkg::ADDR_STATUS:  rd_d = status_w;
         bscc_pkg::ADDR_CONTROL: rd_d = {29'h0, apwrn_q, 1'b0, halt_q};
         bscc_pkg::ADDR_LINK_US: rd_d = {31'h0, us_q};
         bscc_pkg::ADDR_LINK_DS: rd_d = {{(32-NDS){1'b0}}, ds_q};
         // Reference rate in kHz; lane and core rates are fixed by the PLL
         bscc_pkg::ADDR_CLOCKS:  rd_d = s_ref ? bscc_pkg::REF_125_KHZ
                                              : bscc_pkg::REF_100_KHZ;
         default:                rd_d = 32'h0000_0000;
      endcase
   end

   // Output registers; all outputs leave from flip-flops
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prdata         <= 32'h0000_0000;
         pready         <= 1'b0;
         pslverr        <= 1'b0;
         ref_is_125m    <= 1'b0;
         smbus_khz      <= bscc_pkg::SMB_FAST_KHZ;
         eeprom_init_en <= 1'b0;
         low_latency_en <= 1'b0;
         aux_power_en   <= 1'b1;
         sticky_clear   <= 1'b0;
         us_slot_clock  <= 1'b0;
         ds_slot_clock  <= '0;
         switch_halted  <= 1'b0;
         switch_run     <= 1'b0;
      end else begin
         // Ready one cycle into setup, so access phase always ends at once
         pready         <= psel & ~penable;
         prdata         <= (psel & ~penable & ~pwrite) ? rd_d : 32'h0000_0000;
         pslverr        <= psel & ~penable & ~rd_ok;
         ref_is_125m    <= s_ref;
         smbus_khz      <= s_slow ? bscc_pkg::SMB_SLOW_KHZ
                                  : bscc_pkg::SMB_FAST_KHZ;
         eeprom_init_en <= ee_init;
         low_latency_en <= low_lat;
         aux_power_en   <= apwrn_q;
         sticky_clear   <= (st_q == BSCC_LOAD) & ~s_apwrn;
         us_slot_clock  <= us_q;
         ds_slot_clock  <= ds_q;
         switch_halted  <= (st_q == BSCC_HALT);
         switch_run     <= (st_q == BSCC_RUN);
      end
   end

   // Checks
   chk_capture_on_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
      capture |=> held == $past(strap_vec)) else $error("straps not latched");
   chk_pins_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
      !capture |=> held == $past(held)) else $error("straps changed");
   chk_halt_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_q == BSCC_HALT && halt_q && fundamental_reset_in_n && !frst_req) |=> st_q == BSCC_HALT)
      else $error("left halt early");
   chk_halt_seed: assert property (@(posedge core_clk) disable iff (!rst_n)
      st_q == BSCC_LOAD |=> halt_q == $past(s_halt)) else $error("halt not seeded");
   chk_smbus_rate: assert property (@(posedge core_clk) disable iff (!rst_n)
      ##1 smbus_khz == ($past(s_slow) ? 16'd100 : 16'd400)) else $error("smbus rate");
   chk_ds_seed: assert property (@(posedge core_clk) disable iff (!rst_n)
      st_q == BSCC_LOAD |=> ##1 ds_slot_clock == {NDS{$past(s_ds, 2)}})
      else $error("ds seed");
   chk_us_seed: assert property (@(posedge core_clk) disable iff (!rst_n)
      st_q == BSCC_LOAD |=> us_q == $past(s_us)) else $error("us seed");
   chk_sticky_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_q == BSCC_LOAD && !s_apwrn) |=> sticky_q == 32'h0 && sticky_clear)
      else $error("sticky not cleared");
   chk_mode_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
      ##1 low_latency_en == ($past(s_mode) == 3'h2 || $past(s_mode) == 3'h3))
      else $error("mode decode");
   chk_apb_ready: assert property (@(posedge core_clk) disable iff (!rst_n)
      (psel && !penable) |=> pready) else $error("no ready");
endmodule : bscc_top
`default_nettype wire

// ==== testbench/bscc_strap_board.sv ====
`timescale 1ns/1ps
`default_nettype none
// Board side: strap resistors plus the fundamental reset source
module bscc_strap_board (
   // Clock
   input  wire logic       core_clk,
   // Reset pin and strap vector, bit order as in the status word
   output var  logic       fundamental_reset_in_n,
   output var  logic [8:0] straps
);
   // Pin idles high on its pull-up; straps idle on their pull-downs
   initial begin
      fundamental_reset_in_n = 1'b1;
      straps = 9'h000;
   end

   // Cold reset: straps settle while the pin is low and hold past negation.
   // The reference source has no spread spectrum, so non-common clock straps are legal
   // Callers give modes 0 to 3 only, and low latency only with common clock
   task automatic cold(input logic [8:0] v);
      @(posedge core_clk);
      fundamental_reset_in_n <= 1'b0;
      straps                 <= v;
      repeat (4) @(posedge core_clk);
      fundamental_reset_in_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      // Board moves on; a device that keeps sampling would follow
      straps <= v ^ 9'h17f;                 // Mode stays in 0..3
   endtask : cold
endmodule : bscc_strap_board
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        core_clk = 1'b0;
   logic        rst_n, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, ref_is_125m, eeprom_init_en, low_latency_en;
   logic        aux_power_en, sticky_clear, us_slot_clock, switch_halted, switch_run;
   logic [15:0] smbus_khz;
   logic [3:0]  ds_slot_clock;
   wire         fund_n;
   wire  [8:0]  straps;
   int          failures = 0;
   int          compares = 0;
   int          sticky_n = 0;

   // 100 MHz core clock
   always #5 core_clk = ~core_clk;

   bscc_strap_board board (.core_clk(core_clk), .fundamental_reset_in_n(fund_n), .straps(straps));

   bscc_top #(.NDS(4)) i_bscc_top (
      .core_clk(core_clk), .rst_n(rst_n), .fundamental_reset_in_n(fund_n),
      .ref_clock_freq_select(straps[0]), .upstream_common_clock_strap(straps[1]),
      .downstream_common_clock_strap(straps[2]), .master_smbus_slow_strap(straps[3]),
      .reset_halt_strap(straps[4]), .switch_mode_strap(straps[7:5]),
      .aux_power_disable_n(straps[8]), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ref_is_125m(ref_is_125m), .smbus_khz(smbus_khz), .eeprom_init_en(eeprom_init_en),
      .low_latency_en(low_latency_en), .aux_power_en(aux_power_en),
      .sticky_clear(sticky_clear), .us_slot_clock(us_slot_clock),
      .ds_slot_clock(ds_slot_clock), .switch_halted(switch_halted), .switch_run(switch_run));

   // Count sticky clear pulses, so a stuck level shows as many
   always @(posedge core_clk) begin
      if (sticky_clear === 1'b1) sticky_n++;
   end

   task automatic give_verdict;
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   task automatic chkw(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask : chkw

   task automatic chkb(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask : chkb

   // One APB transfer, entered just after a rising edge; holds until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         $display("CHECK FAILED at %0t: no pready", $time);
         give_verdict;
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
      logic [31:0] rd;
      logic        er;
      apb(1'b0, a, 32'h0, rd, er);
      chkw(rd & m, e, what);
      chkb(er, 1'b0, "read error flag");
   endtask : rdchk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, a, d, rd, er);
   endtask : wr

   // Before any pin negation nothing is latched and the switch waits
   task automatic t_reset;
      chkw({16'h0, smbus_khz}, {16'h0, bscc_pkg::SMB_FAST_KHZ}, "reset smbus");
      chkb(aux_power_en, 1'b1, "reset aux");
      chkb(switch_run, 1'b0, "runs before latch");
      rdchk(bscc_pkg::ADDR_STATUS, 32'hfff, 32'h0, "reset status");
   endtask : t_reset

   // Cold reset with a strap vector, then every decoded result
   task automatic t_cold(input logic [8:0] v);
      int sc;
      sc = sticky_n;
      board.cold(v);
      repeat (3) @(posedge core_clk);
      rdchk(bscc_pkg::ADDR_STATUS, 32'h1fff, {19'h0, ~v[4], 1'b0, v[5], v[6], v},
            "status");
      chkb(ref_is_125m, v[0], "ref select");
      rdchk(bscc_pkg::ADDR_CLOCKS, 32'hffffffff,
            v[0] ? bscc_pkg::REF_125_KHZ : bscc_pkg::REF_100_KHZ, "ref rate");
      chkw({16'h0, smbus_khz}, {16'h0, v[3] ? bscc_pkg::SMB_SLOW_KHZ
                                            : bscc_pkg::SMB_FAST_KHZ}, "smbus");
      chkb(eeprom_init_en, v[5], "eeprom mode");
      chkb(low_latency_en, v[6], "latency mode");
      chkb(us_slot_clock, v[1], "us slot");
      chkw({28'h0, ds_slot_clock}, {28'h0, {4{v[2]}}}, "ds slot");
      chkb(aux_power_en, v[8], "aux power");
      chkw(32'(sticky_n - sc), {31'h0, ~v[8]}, "sticky pulses");
      chkb(switch_halted, v[4], "halted");
      chkb(switch_run, ~v[4], "running");
      rdchk(bscc_pkg::ADDR_CONTROL, 32'h7, {29'h0, v[8], 1'b0, v[4]}, "ctl");
      if (v[4]) begin
         wr(bscc_pkg::ADDR_CONTROL, 32'h4);
         // Halt clears at the write edge, state moves next edge, output one later
         repeat (2) @(posedge core_clk);
         chkb(switch_run, 1'b1, "release halt");
      end
   endtask : t_cold

   // Software overrides slot bits, then a soft reset reloads the old straps
   task automatic t_override;
      wr(bscc_pkg::ADDR_LINK_US, 32'h0);
      wr(bscc_pkg::ADDR_LINK_DS, 32'h5);
      chkb(us_slot_clock, 1'b0, "us override");
      rdchk(bscc_pkg::ADDR_LINK_DS, 32'hf, 32'h5, "ds override");
      wr(bscc_pkg::ADDR_CONTROL, 32'h6);
      repeat (8) @(posedge core_clk);
      rdchk(bscc_pkg::ADDR_STATUS, 32'h1ff, 32'h176, "soft reset status");
      chkw({28'h0, ds_slot_clock}, 32'hf, "ds reloaded");
      chkb(switch_halted, 1'b1, "halt again");
      wr(bscc_pkg::ADDR_CONTROL, 32'h4);
   endtask : t_override

   // Unmapped address errors; status ignores writes
   task automatic t_errors;
      logic [31:0] rd;
      logic        er;
      apb(1'b0, 8'h20, 32'h0, rd, er);
      chkb(er, 1'b1, "unmapped error");
      chkw(rd, 32'h0, "unmapped data");
      wr(bscc_pkg::ADDR_STATUS, 32'hffffffff);
      rdchk(bscc_pkg::ADDR_STATUS, 32'h1ff, 32'h176, "status read only");
   endtask : t_errors

   initial begin
      rst_n   = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      t_reset;
      t_cold(9'h101);
      t_cold(9'h12c);
      t_cold(9'h047);
      t_cold(9'h176);
      t_override;
      t_errors;
      give_verdict;
   end
endmodule : testbench
`default_nettype wire
